// *** verilog/hpc_defs.svh ***
// Constants for the host port pin function block.
// Included by the package and the design modules.
`ifndef HPC_DEFS_SVH
`define HPC_DEFS_SVH
`define HPC_ADDR_W        7
`define HPC_DATA_W        16
`define HPC_FIFO_ADDR_LSB 2
`define HPC_PIN_EEPROM    2'h0
`define HPC_PIN_GPO       2'h1
`define HPC_PIN_MON_A     2'h2
`define HPC_PIN_MON_B     2'h3
`define HPC_STRAP_RESET   1'h1
`endif

// *** verilog/hpc_pkg.sv ***
// Types shared by the host port pin function block.
// Assumes hpc_defs.svh is on the include path.
`include "hpc_defs.svh"
package hpc_pkg;
  typedef enum logic [1:0] {
    HPC_FN_EEPROM = `HPC_PIN_EEPROM,
    HPC_FN_GPO    = `HPC_PIN_GPO,
    HPC_FN_MON_A  = `HPC_PIN_MON_A,
    HPC_FN_MON_B  = `HPC_PIN_MON_B
  } hpc_pin_fn_e;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic autoneg_en;
  } hpc_link_cfg_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       fifo;
    logic [6:0] addr;
  } hpc_access_s;
endpackage

// *** verilog/hpc_strap.sv ***
// Link default strap capture.
// Assumes the strap input is stable around reset release.
`timescale 1ns/1ps
`include "hpc_defs.svh"
module hpc_strap
  import hpc_pkg::*;
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    srst,
  // Strap
  input  wire logic    link_default_strap,
  output hpc_link_cfg_s link_cfg
);
  logic strap;
  logic next_strap;
  logic in_reset;
  logic next_in_reset;

  always_comb
  begin
    next_in_reset = srst;
    next_strap    = strap;
    // Follow the pin during reset, freeze on release
    if (srst)
      next_strap = link_default_strap;
  end

  always_ff @(posedge clk)
  begin
    in_reset <= next_in_reset;
    strap    <= next_strap;
  end

  always_comb
  begin
    link_cfg.speed_100   = strap;
    link_cfg.full_duplex = 1'b0;
    link_cfg.autoneg_en  = strap;
  end

  a_strap_hold: assert property (@(posedge clk) disable iff (srst)
    !in_reset |-> $stable(strap))
    else $error("strap value changed after reset release");
  a_strap_map: assert property (@(posedge clk) disable iff (srst)
    link_cfg.speed_100 == link_cfg.autoneg_en && !link_cfg.full_duplex)
    else $error("link defaults do not follow strap");
endmodule

// *** verilog/hpc_pin_mux.sv ***
// Shared EEPROM pin function selection.
// Assumes monitor inputs are already in the clk domain.
`timescale 1ns/1ps
`include "hpc_defs.svh"
module hpc_pin_mux
  import hpc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Function selects
  input  hpc_pin_fn_e      io_fn,
  input  hpc_pin_fn_e      clk_fn,
  // Sources
  input  wire logic        ee_select,
  input  wire logic        ee_clock,
  input  wire logic        ee_data_out,
  input  wire logic        ee_data_oe,
  input  wire logic        gpo_three,
  input  wire logic        gpo_four,
  input  wire logic        mii_tx_en,
  input  wire logic        mii_tx_clk,
  input  wire logic        mii_rx_dv,
  input  wire logic        mii_rx_clk,
  // Pins
  output logic             eeprom_select,
  output logic             eeprom_serial_clock,
  output logic             eeprom_serial_io_out,
  output logic             eeprom_serial_io_oe
);
  logic next_sel;
  logic next_clk;
  logic next_io;
  logic next_oe;
  logic shared;

  always_comb
  begin
    shared  = (io_fn != HPC_FN_EEPROM) || (clk_fn != HPC_FN_EEPROM);
    next_sel = shared ? 1'b0 : ee_select;
    next_io  = ee_data_out;
    next_oe  = ee_data_oe;
    unique case (io_fn)
      HPC_FN_EEPROM: next_io = ee_data_out;
      HPC_FN_GPO:
      begin
        next_io = gpo_three;
        next_oe = 1'b1;
      end
      HPC_FN_MON_A:
      begin
        next_io = mii_tx_en;
        next_oe = 1'b1;
      end
      HPC_FN_MON_B:
      begin
        next_io = mii_tx_clk;
        next_oe = 1'b1;
      end
    endcase
    unique case (clk_fn)
      HPC_FN_EEPROM: next_clk = ee_clock;
      HPC_FN_GPO:    next_clk = gpo_four;
      HPC_FN_MON_A:  next_clk = mii_rx_dv;
      HPC_FN_MON_B:  next_clk = mii_rx_clk;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      eeprom_select        <= 1'b0;
      eeprom_serial_clock  <= 1'b0;
      eeprom_serial_io_out <= 1'b0;
      eeprom_serial_io_oe  <= 1'b0;
    end
    else
    begin
      eeprom_select        <= next_sel;
      eeprom_serial_clock  <= next_clk;
      eeprom_serial_io_out <= next_io;
      eeprom_serial_io_oe  <= next_oe;
    end
  end

  a_sel_blocked: assert property (@(posedge clk) disable iff (srst)
    (io_fn != HPC_FN_EEPROM || clk_fn != HPC_FN_EEPROM) |=> !eeprom_select)
    else $error("eeprom select active while pin shared");
  a_gpo_drives: assert property (@(posedge clk) disable iff (srst)
    io_fn == HPC_FN_GPO |=> eeprom_serial_io_oe && eeprom_serial_io_out == $past(gpo_three))
    else $error("general output three not driven");
  a_clk_gpo: assert property (@(posedge clk) disable iff (srst)
    clk_fn == HPC_FN_GPO |=> eeprom_serial_clock == $past(gpo_four))
    else $error("general output four not driven");
  a_ee_mode: assert property (@(posedge clk) disable iff (srst)
    io_fn == HPC_FN_EEPROM |=> eeprom_serial_io_oe == $past(ee_data_oe))
    else $error("eeprom data direction not followed");
endmodule

// *** verilog/hpc_host_port.sv ***
// Behaviour
// - With direct-FIFO select high, every access goes to the data FIFOs and A[7:3] are ignored.
// - The 7-bit address on lines 1..7 picks a control register or a data FIFO.
// - Chip select with the read strobe low is a read of the selected location.
// - Chip select with the write strobe low stores the data bus to the selected location, once a read has followed reset or wake.
// - Strobes without chip select start nothing.
// - A qualified write strobe brings the device out of reduced power.
// - The interrupt pin has selectable sources, push-pull or open-drain drive, and selectable polarity in push-pull.
// - Strap 0 gives 10 Mbps half duplex no negotiation, 1 gives 100 Mbps half duplex with it.
// - A detected or forced reversal swaps the transmit and receive pairs.
// - In EEPROM mode the data pin is a two-way serial line.
// - The data pin can be general output three or a TX_EN or TX_CLK monitor.
// - The clock pin can be general output four or an RX_DV or RX_CLK monitor.
// - While either pin is borrowed, the EEPROM select stays inactive.
// - General outputs three and four have no input function.
// - The strap is captured at reset release and held.
//
// Top of the host port pin function block.
// Assumes host strobes are synchronous to clk; internal targets accept access pulses.
`timescale 1ns/1ps
`include "hpc_defs.svh"
module hpc_host_port
  import hpc_pkg::*;
#(
  parameter int ADDR_W = `HPC_ADDR_W,
  parameter int DATA_W = `HPC_DATA_W
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Host bus
  input  wire logic              chip_select_n,
  input  wire logic              read_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic              fifo_select,
  input  wire logic [ADDR_W:1]   host_addr,
  input  wire logic [DATA_W-1:0] host_data_in,
  output logic      [DATA_W-1:0] host_data_out,
  output logic                   host_data_oe,
  // Internal access
  output hpc_access_s            access,
  output logic      [DATA_W-1:0] write_data,
  input  wire logic [DATA_W-1:0] read_data,
  // Power
  input  wire logic              enter_low_power,
  output logic                   low_power,
  output logic                   wake_event,
  // Interrupt pin
  input  wire logic [7:0]        irq_sources,
  input  wire logic [7:0]        irq_enable,
  input  wire logic              irq_active_high,
  input  wire logic              irq_push_pull,
  output logic                   irq_out,
  output logic                   irq_oe,
  // Twisted pair
  input  wire logic              auto_reverse_detected,
  input  wire logic              auto_crossover_en,
  input  wire logic              manual_reverse,
  output logic                   pairs_swapped,
  // Link defaults
  input  wire logic              link_default_strap,
  output hpc_link_cfg_s          link_cfg,
  // Shared EEPROM pins
  input  hpc_pin_fn_e            io_fn,
  input  hpc_pin_fn_e            clk_fn,
  input  wire logic              ee_select,
  input  wire logic              ee_clock,
  input  wire logic              ee_data_out,
  input  wire logic              ee_data_oe,
  input  wire logic              eeprom_serial_io_in,
  output logic                   ee_data_in,
  input  wire logic              general_output_three,
  input  wire logic              general_output_four,
  input  wire logic              mii_tx_en,
  input  wire logic              mii_tx_clk,
  input  wire logic              mii_rx_dv,
  input  wire logic              mii_rx_clk,
  output logic                   eeprom_select,
  output logic                   eeprom_serial_clock,
  output logic                   eeprom_serial_io_out,
  output logic                   eeprom_serial_io_oe
);
  logic              rd_q;
  logic              wr_q;
  logic              unlocked;
  logic              next_unlocked;
  logic              next_low_power;
  logic              next_wake;
  logic              rd_now;
  logic              wr_now;
  hpc_access_s       next_access;
  logic [DATA_W-1:0] next_wdata;
  logic [DATA_W-1:0] next_rdata;
  logic              next_doe;
  logic              next_irq_out;
  logic              next_irq_oe;
  logic              next_swap;
  logic              irq_hit;

  // Qualified strobes
  assign rd_now = !chip_select_n && !read_strobe_n;
  assign wr_now = !chip_select_n && !write_strobe_n;

  always_comb
  begin
    next_access       = '0;
    next_wdata        = write_data;
    next_unlocked     = unlocked;
    next_low_power    = low_power;
    next_wake         = 1'b0;
    next_access.fifo  = fifo_select;
    next_access.addr  = host_addr;
    if (fifo_select)
      next_access.addr = {{(ADDR_W-`HPC_FIFO_ADDR_LSB){1'b0}},
                          host_addr[`HPC_FIFO_ADDR_LSB:1]};
    // One pulse per strobe, taken on its leading edge
    if (rd_now && !rd_q)
    begin
      next_access.valid = 1'b1;
      next_unlocked     = 1'b1;
    end
    else if (wr_now && !wr_q)
    begin
      if (low_power)
      begin
        // Waking write is not a data write, and a read must follow
        next_low_power = 1'b0;
        next_wake      = 1'b1;
        next_unlocked  = 1'b0;
      end
      else if (unlocked)
      begin
        next_access.valid = 1'b1;
        next_access.write = 1'b1;
        next_wdata        = host_data_in;
      end
    end
    // A sleep request wins over a waking write in the same cycle
    if (enter_low_power)
    begin
      next_low_power = 1'b1;
      next_unlocked  = 1'b0;
    end
    next_doe   = rd_now;
    next_rdata = rd_now ? read_data : host_data_out;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_q          <= 1'b0;
      wr_q          <= 1'b0;
      unlocked      <= 1'b0;
      low_power     <= 1'b0;
      wake_event    <= 1'b0;
      access        <= '0;
      write_data    <= '0;
      host_data_out <= '0;
      host_data_oe  <= 1'b0;
    end
    else
    begin
      rd_q          <= rd_now;
      wr_q          <= wr_now;
      unlocked      <= next_unlocked;
      low_power     <= next_low_power;
      wake_event    <= next_wake;
      access        <= next_access;
      write_data    <= next_wdata;
      host_data_out <= next_rdata;
      host_data_oe  <= next_doe;
    end
  end

  // Interrupt pin and pair swap
  always_comb
  begin
    irq_hit      = |(irq_sources & irq_enable);
    next_irq_out = irq_hit ? irq_active_high : !irq_active_high;
    // Open drain drives only the active low level
    next_irq_oe  = irq_push_pull || irq_hit;
    if (!irq_push_pull)
      next_irq_out = 1'b0;
    next_swap = (auto_crossover_en && auto_reverse_detected) || manual_reverse;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irq_out       <= 1'b0;
      irq_oe        <= 1'b0;
      pairs_swapped <= 1'b0;
    end
    else
    begin
      irq_out       <= next_irq_out;
      irq_oe        <= next_irq_oe;
      pairs_swapped <= next_swap;
    end
  end

  // EEPROM data only reaches the EEPROM engine in EEPROM mode
  assign ee_data_in = (io_fn == HPC_FN_EEPROM) ? eeprom_serial_io_in : 1'b0;

  hpc_strap u_strap (
    .clk                (clk),
    .srst               (srst),
    .link_default_strap (link_default_strap),
    .link_cfg           (link_cfg)
  );

  hpc_pin_mux u_pin_mux (
    .clk                  (clk),
    .srst                 (srst),
    .io_fn                (io_fn),
    .clk_fn               (clk_fn),
    .ee_select            (ee_select),
    .ee_clock             (ee_clock),
    .ee_data_out          (ee_data_out),
    .ee_data_oe           (ee_data_oe),
    .gpo_three            (general_output_three),
    .gpo_four             (general_output_four),
    .mii_tx_en            (mii_tx_en),
    .mii_tx_clk           (mii_tx_clk),
    .mii_rx_dv            (mii_rx_dv),
    .mii_rx_clk           (mii_rx_clk),
    .eeprom_select        (eeprom_select),
    .eeprom_serial_clock  (eeprom_serial_clock),
    .eeprom_serial_io_out (eeprom_serial_io_out),
    .eeprom_serial_io_oe  (eeprom_serial_io_oe)
  );

  // Leading edges of the qualified strobes; a held strobe is one access
  sequence s_rd_edge;
    !rd_q && rd_now;
  endsequence

  sequence s_wr_edge;
    !wr_q && wr_now;
  endsequence

  // A read edge wins over a write edge in the same cycle
  sequence s_wr_only;
    s_wr_edge and !rd_now;
  endsequence

  a_no_cs_idle: assert property (@(posedge clk) disable iff (srst)
    chip_select_n |=> !access.valid)
    else $error("access started without chip select");
  a_fifo_addr: assert property (@(posedge clk) disable iff (srst)
    fifo_select |=> access.fifo && access.addr[ADDR_W-1:`HPC_FIFO_ADDR_LSB] == '0)
    else $error("upper address used in fifo mode");
  a_reg_addr: assert property (@(posedge clk) disable iff (srst)
    !fifo_select |=> !access.fifo && access.addr == $past(host_addr))
    else $error("register address not passed through");
  a_wake_write: assert property (@(posedge clk) disable iff (srst)
    (s_wr_only and low_power and !enter_low_power) |=>
      !low_power && wake_event && !access.valid)
    else $error("qualified write did not wake");
  a_wake_single: assert property (@(posedge clk) disable iff (srst)
    wake_event |=> !wake_event)
    else $error("wake event longer than one cycle");
  a_sleep_set: assert property (@(posedge clk) disable iff (srst)
    enter_low_power |=> low_power && !unlocked)
    else $error("low power request not taken");
  a_locked_write: assert property (@(posedge clk) disable iff (srst)
    (s_wr_edge and !unlocked) |=> !access.write)
    else $error("write honoured before first read");
  a_read_unlock: assert property (@(posedge clk) disable iff (srst)
    (s_rd_edge and !enter_low_power) |=> unlocked)
    else $error("read did not unlock writes");
  a_read_pulse: assert property (@(posedge clk) disable iff (srst)
    s_rd_edge |=> access.valid && !access.write ##1 !(access.valid && !access.write))
    else $error("read strobe gave no single pulse");
  a_read_data: assert property (@(posedge clk) disable iff (srst)
    rd_now |=> host_data_oe && host_data_out == $past(read_data))
    else $error("read data not presented");
  a_read_off: assert property (@(posedge clk) disable iff (srst)
    !rd_now |=> !host_data_oe)
    else $error("data bus driven without a read");
  a_write_data: assert property (@(posedge clk) disable iff (srst)
    (s_wr_only and unlocked and !low_power) |=>
      access.write && write_data == $past(host_data_in))
    else $error("write data not captured");
  a_irq_level: assert property (@(posedge clk) disable iff (srst)
    (irq_push_pull && irq_hit) |=> irq_oe && irq_out == $past(irq_active_high))
    else $error("interrupt level wrong");
  a_irq_drain: assert property (@(posedge clk) disable iff (srst)
    !irq_push_pull |=> !irq_out && irq_oe == $past(irq_hit))
    else $error("open drain interrupt drive wrong");
  a_pair_swap: assert property (@(posedge clk) disable iff (srst)
    manual_reverse |=> pairs_swapped)
    else $error("manual reversal not applied");
  a_pair_auto: assert property (@(posedge clk) disable iff (srst)
    (auto_crossover_en && auto_reverse_detected) |=> pairs_swapped)
    else $error("detected reversal not applied");
  a_pair_normal: assert property (@(posedge clk) disable iff (srst)
    (!manual_reverse && !auto_reverse_detected) |=> !pairs_swapped)
    else $error("pairs swapped without reversal");
  a_ee_gate: assert property (@(posedge clk) disable iff (srst)
    io_fn != HPC_FN_EEPROM |-> !ee_data_in)
    else $error("shared data pin fed back as input");
endmodule

// *** tb/hpc_host_model.sv ***
// Host processor model on the asynchronous SRAM-like port.
// Assumes the bench calls one task at a time; signals move 1 ns after clk rises.
`timescale 1ns/1ps
module hpc_host_model
  import hpc_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Host bus
  output logic             chip_select_n,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic             fifo_select,
  output logic [7:1]       host_addr,
  output logic [15:0]      host_data_in,
  input  wire logic [15:0] host_data_out,
  input  wire logic        host_data_oe
);
  initial
  begin
    chip_select_n  = 1'b1;
    read_strobe_n  = 1'b1;
    write_strobe_n = 1'b1;
    fifo_select    = 1'b0;
    host_addr      = 7'h00;
    host_data_in   = 16'h0000;
  end

  // Released data shows the inverse, so a stale word never looks valid
  task automatic release_bus();
    chip_select_n  = 1'b1;
    read_strobe_n  = 1'b1;
    write_strobe_n = 1'b1;
    host_data_in   = ~host_data_in;
  endtask

  task automatic bus_read(input logic sel, input logic fs, input logic [7:1] a,
                          output logic [15:0] d, output logic oe);
    @(posedge clk);
    #1;
    fifo_select   = fs;
    host_addr     = a;
    chip_select_n = ~sel;
    read_strobe_n = 1'b0;
    @(posedge clk);
    #1;
    d  = host_data_out;
    oe = host_data_oe;
    @(posedge clk);
    #1;
    release_bus();
  endtask

  task automatic bus_write(input logic sel, input logic fs, input logic [7:1] a,
                           input logic [15:0] d);
    @(posedge clk);
    #1;
    fifo_select    = fs;
    host_addr      = a;
    host_data_in   = d;
    chip_select_n  = ~sel;
    write_strobe_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    release_bus();
  endtask
endmodule

// *** tb/host_port_pin_function_config_test.sv ***
// Self-checking bench for the host port pin function block.
// Assumes hpc_pkg and the design are compiled first; host bus comes from hpc_host_model.
`timescale 1ns/1ps
module host_port_pin_function_config_test
  import hpc_pkg::*;
;
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  logic          chip_select_n, read_strobe_n, write_strobe_n, fifo_select, host_data_oe;
  logic [7:1]    host_addr;
  logic [15:0]   host_data_in, host_data_out, write_data, read_data, rd_d;
  logic          rd_oe, enter_low_power, low_power, wake_event, ee_ext;
  logic [7:0]    irq_sources, irq_enable;
  logic          irq_active_high, irq_push_pull, irq_out, irq_oe, pairs_swapped;
  logic          auto_reverse_detected, auto_crossover_en, manual_reverse, link_default_strap;
  hpc_access_s   access, last_acc;
  hpc_link_cfg_s link_cfg;
  hpc_pin_fn_e   io_fn, clk_fn;
  logic          ee_select, ee_clock, ee_data_out, ee_data_oe, eeprom_serial_io_in, ee_data_in;
  logic          general_output_three, general_output_four;
  logic          mii_tx_en, mii_tx_clk, mii_rx_dv, mii_rx_clk;
  logic          eeprom_select, eeprom_serial_clock, eeprom_serial_io_out, eeprom_serial_io_oe;
  logic [9:0]    src;
  logic [3:0]    iov, ckv;
  logic [4:0]    pin_exp;
  int            fails = 0, samples_checked = 0, acc_count = 0, wake_count = 0;

  assign {ee_select, ee_clock, ee_data_out, ee_data_oe, general_output_three,
          general_output_four, mii_tx_en, mii_tx_clk, mii_rx_dv, mii_rx_clk} = src;
  // Far EEPROM drives the shared pin only while the block lets go
  assign eeprom_serial_io_in = eeprom_serial_io_oe ? eeprom_serial_io_out : ee_ext;

  always #2 clk = ~clk;

  hpc_host_port dut (.clk, .srst, .chip_select_n, .read_strobe_n, .write_strobe_n,
    .fifo_select, .host_addr, .host_data_in, .host_data_out, .host_data_oe, .access,
    .write_data, .read_data, .enter_low_power, .low_power, .wake_event, .irq_sources,
    .irq_enable, .irq_active_high, .irq_push_pull, .irq_out, .irq_oe,
    .auto_reverse_detected, .auto_crossover_en, .manual_reverse, .pairs_swapped,
    .link_default_strap, .link_cfg, .io_fn, .clk_fn, .ee_select, .ee_clock, .ee_data_out,
    .ee_data_oe, .eeprom_serial_io_in, .ee_data_in, .general_output_three,
    .general_output_four, .mii_tx_en, .mii_tx_clk, .mii_rx_dv, .mii_rx_clk, .eeprom_select,
    .eeprom_serial_clock, .eeprom_serial_io_out, .eeprom_serial_io_oe);

  hpc_host_model host (.clk, .chip_select_n, .read_strobe_n, .write_strobe_n, .fifo_select,
    .host_addr, .host_data_in, .host_data_out, .host_data_oe);

  always @(posedge clk)
  begin
    if (access.valid === 1'b1)
    begin
      last_acc  <= access;
      acc_count <= acc_count + 1;
    end
    if (wake_event === 1'b1)
      wake_count <= wake_count + 1;
  end

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_acc(input hpc_access_s got, input hpc_access_s exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic strap);
    link_default_strap = strap;
    srst = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
  endtask

  task automatic wrap_up();
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    read_data = 16'hc3a5;
    enter_low_power = 1'b0;
    irq_sources = 8'h5a;
    irq_enable = 8'h00;
    {irq_active_high, irq_push_pull} = 2'h3;
    {auto_reverse_detected, auto_crossover_en, manual_reverse} = 3'h0;
    io_fn = HPC_FN_EEPROM;
    clk_fn = HPC_FN_EEPROM;
    src = 10'h000;
    ee_ext = 1'b0;
    do_reset(1'b0);
    tick();
    check_val(link_cfg, 16'h0000);
    link_default_strap = 1'b1;
    repeat (2) tick();
    check_val(link_cfg, 16'h0000);
    host.bus_write(1'b1, 1'b0, 7'h10, 16'h1234);
    check_val(acc_count[15:0], 16'h0000);
    host.bus_read(1'b1, 1'b0, 7'h2a, rd_d, rd_oe);
    check_acc(last_acc, {3'b100, 7'h2a});
    check_val(rd_d, read_data);
    check_val(rd_oe, 16'h0001);
    host.bus_write(1'b1, 1'b0, 7'h55, 16'hbeef);
    check_acc(last_acc, {3'b110, 7'h55});
    check_val(write_data, 16'hbeef);
    host.bus_read(1'b1, 1'b1, 7'h7f, rd_d, rd_oe);
    check_acc(last_acc, {3'b101, 7'h03});
    host.bus_write(1'b1, 1'b1, 7'h7d, 16'h0f0f);
    check_acc(last_acc, {3'b111, 7'h01});
    host.bus_write(1'b0, 1'b0, 7'h22, 16'h5555);
    host.bus_read(1'b0, 1'b0, 7'h22, rd_d, rd_oe);
    check_val(acc_count[15:0], 16'h0004);
    check_val(rd_oe, 16'h0000);
    check_val(write_data, 16'h0f0f);
    enter_low_power = 1'b1;
    tick();
    enter_low_power = 1'b0;
    tick();
    check_val(low_power, 16'h0001);
    host.bus_write(1'b1, 1'b0, 7'h33, 16'h7777);
    tick();
    check_val(wake_count[15:0], 16'h0001);
    check_val(low_power, 16'h0000);
    host.bus_write(1'b1, 1'b0, 7'h33, 16'h7777);
    check_val(acc_count[15:0], 16'h0004);
    for (int i = 0; i < 8; i++)
    begin
      {irq_active_high, irq_push_pull} = i[2:1];
      irq_enable = i[0] ? 8'h02 : 8'ha5;
      tick();
      check_val({irq_out, irq_oe}, i[1] ? {~(i[2] ^ i[0]), 1'b1} : {1'b0, i[0]});
    end
    for (int i = 0; i < 8; i++)
    begin
      {auto_reverse_detected, auto_crossover_en, manual_reverse} = i[2:0];
      tick();
      check_val(pairs_swapped, (i[2] & i[1]) | i[0]);
    end
    // Two source patterns so every pair of candidate sources differs once
    for (int i = 0; i < 32; i++)
    begin
      io_fn = hpc_pin_fn_e'(i[1:0]);
      clk_fn = hpc_pin_fn_e'(i[3:2]);
      src = i[4] ? 10'h369 : 10'h099;
      ee_ext = ~i[4];
      tick();
      iov = {mii_tx_clk, mii_tx_en, general_output_three, ee_data_out};
      ckv = {mii_rx_clk, mii_rx_dv, general_output_four, ee_clock};
      pin_exp[4] = (io_fn == HPC_FN_EEPROM && clk_fn == HPC_FN_EEPROM) ? ee_select : 1'b0;
      pin_exp[3] = ckv[clk_fn];
      pin_exp[2] = iov[io_fn];
      pin_exp[1] = (io_fn == HPC_FN_EEPROM) ? ee_data_oe : 1'b1;
      pin_exp[0] = (io_fn == HPC_FN_EEPROM) ? (ee_data_oe ? ee_data_out : ee_ext) : 1'b0;
      check_val({eeprom_select, eeprom_serial_clock, eeprom_serial_io_out,
                 eeprom_serial_io_oe, ee_data_in}, pin_exp);
    end
    do_reset(1'b1);
    tick();
    check_val(link_cfg, 16'h0005);
    wrap_up();
  end

  // Run needs about 115 cycles; many times that means a hang
  initial
  begin
    #20000;
    fails++;
    wrap_up();
  end
endmodule
